//--- common/fpec_pkg.sv
// constants and types for the flash page erase controller
// assumes a 10 MHz system clock and a 16-bit cpu address space
// Notes on behaviour
// R1 - erase page is 64 bytes aligned on 64-byte boundaries
// R2 - the 48-byte vector area forms its own erase page
// R3 - any page may be erased alone, nothing else touched
// R4 - software first sets erase select and clears whole-array select
// R5 - software then reads the block protect register
// R6 - software writes any value inside the target page
// R7 - software waits at least 10 us, then sets high voltage enable
// R8 - software holds high voltage for 1 ms or 4 ms, clears erase
// R9 - software waits at least 5 us, then clears high voltage enable
// R10 - array readable again about 1 us after high voltage drops
// R11 - software keeps step order; unrelated work between steps allowed
// R12 - erase code must not run from the flash array
// R13 - erasing the vector page also erases both trim bytes
// R14 - use 4 ms erase above 1000 cycles, 1 ms otherwise
// R15 - erase select and program select are never both set
// R16 - page latched from step-three write; voltage only with erase and enable
package fpec_pkg;
    localparam int unsigned FPEC_CLK_HZ = 10_000_000;
    localparam int unsigned FPEC_T_RCV_NS = 1000;
    localparam logic [7:0] FPEC_RCV_CYC =
        8'((FPEC_T_RCV_NS * (FPEC_CLK_HZ / 1_000_000) + 999) / 1000);
    // software wait spans at 100 ns a cycle, used by the bench stimulus
    localparam int FPEC_NVS_CYC = 100;
    localparam int FPEC_ERASE_CYC = 10_000;
    localparam int FPEC_NVH_CYC = 50;
    // register and array area addresses on the plain port
    localparam logic [15:0] FPEC_ADDR_CTRL = 16'hfe08;
    localparam logic [15:0] FPEC_ADDR_PROT = 16'hffbe;
    localparam logic [15:0] FPEC_ADDR_STAT = 16'hfe0e;
    localparam logic [15:0] FPEC_FLASH_LO = 16'hf000;
    localparam logic [15:0] FPEC_VEC_LO = 16'hffd0;
    localparam logic [15:0] FPEC_TRIM_HI = 16'hffc0;
    // control register bit positions
    localparam int FPEC_B_PGM = 0;
    localparam int FPEC_B_ERASE = 1;
    localparam int FPEC_B_MASS = 2;
    localparam int FPEC_B_HIGH_VOLTAGE_ENABLE = 3;
    localparam logic [7:0] FPEC_PROT_RST = 8'hff;
    typedef enum logic [3:0] {
        FPEC_IDLE = 4'h1,
        FPEC_ARMED = 4'h2,
        FPEC_HV = 4'h4,
        FPEC_RCV = 4'h8
    } fpec_state_e;
endpackage

//--- dv/fpec_top_tb.sv
// self-checking bench for the flash page erase controller
// assumes the register port and the control outputs of fpec_top only
`timescale 1ns/1ps
`default_nettype none
module fpec_top_tb import fpec_pkg::*;;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [9:0] page;
    logic vec, trim, hv, rok;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #50 clk = ~clk;
    fpec_top uut (.sys_clk_in(clk), .rst_in(rst), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .page_out(page), .vec_page_out(vec), .trim_erase_out(trim),
        .erase_hv_out(hv), .read_ok_out(rok));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic bw(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic br(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic t_reset();
        logic [7:0] d;
        chk(rok, 1'b1);
        chk(hv, 1'b0);
        chk(page, 10'h000);
        br(FPEC_ADDR_PROT, d);
        chk(d, FPEC_PROT_RST);
        br(FPEC_ADDR_CTRL, d);
        chk(d, 8'h00);
        br(16'h0040, d);
        chk(d, 8'h00);
    endtask
    // reset in mid-sequence drops the armed page and the select bits
    task automatic t_rerst();
        logic [7:0] d;
        bw(FPEC_ADDR_CTRL, 8'h02);
        br(FPEC_ADDR_PROT, d);
        bw(16'hf100, 8'h00);
        #1 chk(page, 10'h3c4);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk(page, 10'h000);
        chk(rok, 1'b1);
        br(FPEC_ADDR_STAT, d);
        chk(d, 8'h01);
        br(FPEC_ADDR_CTRL, d);
        chk(d, 8'h00);
    endtask
    task automatic t_lock();
        logic [7:0] d;
        bw(FPEC_ADDR_CTRL, 8'h03);
        br(FPEC_ADDR_CTRL, d);
        chk(d, 8'h00);
        bw(FPEC_ADDR_CTRL, 8'h02);
        bw(FPEC_ADDR_CTRL, 8'h03);
        br(FPEC_ADDR_CTRL, d);
        chk(d, 8'h02);
        bw(FPEC_ADDR_CTRL, 8'h00);
    endtask
    // full sequence; a page write before the protect read must not latch
    task automatic t_erase(input logic [15:0] a, input logic v);
        logic [7:0] d;
        logic [9:0] p;
        p = page;
        bw(FPEC_ADDR_CTRL, 8'h02);
        bw(a, 8'h5a);
        #1 chk(page, p);
        br(FPEC_ADDR_PROT, d);
        bw(a, 8'ha5);
        #1 chk(page, a[15:6]);
        chk(vec, v);
        chk(rok, 1'b1);
        repeat (FPEC_NVS_CYC) @(posedge clk);
        bw(FPEC_ADDR_CTRL, 8'h0a);
        repeat (2) @(posedge clk);
        #1 chk(hv, 1'b1);
        chk(trim, v);
        chk(rok, 1'b0);
        chk(page, a[15:6]);
        br(FPEC_ADDR_STAT, d);
        chk(d, 8'h04);
        // short erase: few cycles expected, speed wanted
        repeat (FPEC_ERASE_CYC) @(posedge clk);
        bw(FPEC_ADDR_CTRL, 8'h08);
        repeat (2) @(posedge clk);
        #1 chk(hv, 1'b0);
        chk(trim, 1'b0);
        repeat (FPEC_NVH_CYC) @(posedge clk);
        bw(FPEC_ADDR_CTRL, 8'h00);
        repeat (FPEC_RCV_CYC) @(posedge clk);
        #1 chk(rok, 1'b0);
        @(posedge clk);
        #1 chk(rok, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // run is about 20.4k cycles, two short erases; bound is near twice that
    initial begin
        #4_000_000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1 t_reset();
        t_lock();
        // bench drives the port itself, nothing runs from the array
        t_erase(16'hf0c5, 1'b0);
        t_rerst();
        t_erase(16'hffd3, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire

//--- rtl/fpec_top.sv
// flash page erase control: control bits, page latch, erase strobes
// assumes the cpu bus master on the same clock; no flash array model here
`timescale 1ns/1ps
`default_nettype none
module fpec_top
    import fpec_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // flash array controls
    output logic [9:0] page_out,
    output logic vec_page_out,
    output logic trim_erase_out,
    output logic erase_hv_out,
    output logic read_ok_out
);
    typedef struct packed {
        logic program_select_bit;
        logic erase;
        logic mass;
        logic high_voltage_enable;
        logic [7:0] prot;
        logic prot_read;
        logic [9:0] page;
        logic vec;
        logic [7:0] rcv_cnt;
        fpec_state_e st;
        logic [7:0] rdata;
        logic hv_drive;
        logic trim;
        logic read_ok;
    } fpec_s;

    fpec_s s_reg, s_next;

    function automatic logic in_flash(input logic [15:0] a);
        in_flash = (a >= FPEC_FLASH_LO);
    endfunction

    function automatic logic in_vec(input logic [15:0] a);
        in_vec = (a >= FPEC_VEC_LO);
    endfunction

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 8'h00;
        if (wr_in && addr_in == FPEC_ADDR_CTRL) begin
            s_next.mass = wdata_in[FPEC_B_MASS];
            s_next.high_voltage_enable = wdata_in[FPEC_B_HIGH_VOLTAGE_ENABLE];
            // interlock: a request to set both keeps the old pair
            if (!(wdata_in[FPEC_B_PGM] && wdata_in[FPEC_B_ERASE])) begin // see R15
                s_next.program_select_bit = wdata_in[FPEC_B_PGM] && !s_reg.erase;
                s_next.erase = wdata_in[FPEC_B_ERASE] && !s_reg.program_select_bit;
                if (!wdata_in[FPEC_B_ERASE])
                    s_next.erase = 1'b0;
                if (!wdata_in[FPEC_B_PGM])
                    s_next.program_select_bit = 1'b0;
            end
            if (!wdata_in[FPEC_B_ERASE])
                s_next.prot_read = 1'b0;
        end
        if (rd_in) begin
            unique case (addr_in)
                FPEC_ADDR_CTRL: s_next.rdata = {4'h0, s_reg.high_voltage_enable, s_reg.mass,
                    s_reg.erase, s_reg.program_select_bit};
                FPEC_ADDR_PROT: s_next.rdata = s_reg.prot;
                FPEC_ADDR_STAT: s_next.rdata = {4'h0, s_reg.st};
                default: s_next.rdata = 8'h00;
            endcase
            if (addr_in == FPEC_ADDR_PROT && s_reg.erase && !s_reg.mass)
                s_next.prot_read = 1'b1;
        end
        if (wr_in && addr_in == FPEC_ADDR_PROT)
            s_next.prot = wdata_in;
        unique case (s_reg.st)
            FPEC_IDLE: begin
                // data value ignored, only the address picks the page
                if (wr_in && in_flash(addr_in) && s_reg.prot_read
                    && s_reg.erase && !s_reg.mass) begin // see R16
                    s_next.vec = in_vec(addr_in); // see R2
                    s_next.page = addr_in[15:6]; // see R1
                    s_next.st = FPEC_ARMED;
                end
            end
            FPEC_ARMED: begin
                if (!s_reg.erase)
                    s_next.st = FPEC_IDLE;
                else if (s_reg.high_voltage_enable)
                    s_next.st = FPEC_HV;
            end
            FPEC_HV: begin
                // array stays blocked until voltage is gone
                if (!s_reg.high_voltage_enable) begin
                    s_next.st = FPEC_RCV;
                    s_next.rcv_cnt = FPEC_RCV_CYC; // see R10
                end
            end
            FPEC_RCV: begin
                if (s_reg.rcv_cnt <= 8'h01)
                    s_next.st = FPEC_IDLE;
                else
                    s_next.rcv_cnt = s_reg.rcv_cnt - 8'h01;
            end
        endcase
        // only the latched page sees voltage; others are untouched
        s_next.hv_drive = (s_next.st == FPEC_HV) && s_next.erase
            && s_next.high_voltage_enable; // see R3 see R16
        s_next.trim = s_next.hv_drive && s_next.vec; // see R13
        s_next.read_ok = (s_next.st == FPEC_IDLE)
            || (s_next.st == FPEC_ARMED && !s_next.high_voltage_enable); // see R10
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s_reg <= '0;
            s_reg.prot <= FPEC_PROT_RST;
            s_reg.st <= FPEC_IDLE;
            s_reg.read_ok <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata_out = s_reg.rdata;
    assign page_out = s_reg.page;
    assign vec_page_out = s_reg.vec;
    assign trim_erase_out = s_reg.trim;
    assign erase_hv_out = s_reg.hv_drive;
    assign read_ok_out = s_reg.read_ok;

    // step-wise check of the recovery tail
    sequence hv_drop_s;
        s_reg.st == FPEC_HV && !s_reg.high_voltage_enable;
    endsequence

    // the array stays blocked for a while after voltage drops
    sequence rcv_hold_s;
        !read_ok_out [*8];
    endsequence

    // a page write that arms the sequence
    sequence arm_s;
        s_reg.st == FPEC_IDLE && s_next.st == FPEC_ARMED;
    endsequence

    // last recovery cycle
    sequence rcv_end_s;
        s_reg.st == FPEC_RCV && s_reg.rcv_cnt <= 8'h01;
    endsequence

    a_rcv_min_time: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) hv_drop_s |=> rcv_hold_s) // see R10
        else $error("array readable too soon after voltage drop");

    a_rcv_entry: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) hv_drop_s |=> s_reg.st == FPEC_RCV) // see R10
        else $error("recovery not entered after voltage drop");

    a_rcv_exit: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) rcv_end_s |=> s_reg.st == FPEC_IDLE) // see R10
        else $error("recovery did not end");

    a_read_ok_idle: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) s_reg.st == FPEC_IDLE |-> read_ok_out) // see R10
        else $error("idle array not readable");

    a_arm_needs_read: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) arm_s |-> s_reg.prot_read) // see R16
        else $error("page armed without protect read");

    a_arm_not_mass: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) arm_s |-> s_reg.erase && !s_reg.mass) // see R16
        else $error("page armed without page erase selected");

    a_armed_abort: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        s_reg.st == FPEC_ARMED && !s_reg.erase |=> s_reg.st == FPEC_IDLE) // see R16
        else $error("armed state kept without erase select");

    a_page_held: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) s_reg.st != FPEC_IDLE |=> $stable(page_out)) // see R3
        else $error("page changed during an erase");

    a_vec_top_page: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) vec_page_out |-> page_out == 10'h3ff) // see R2
        else $error("vector flag outside the top page");

    a_trim_with_vec: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        erase_hv_out && vec_page_out |-> trim_erase_out) // see R13
        else $error("vector page erased but trim kept");

    a_hv_from_armed: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        $rose(erase_hv_out) |-> $past(s_reg.st) == FPEC_ARMED) // see R16
        else $error("erase voltage without an armed page");

    a_rdata_quiet: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) !rd_in |=> rdata_out == 8'h00) // see R5
        else $error("read data outside the read answer cycle");

    a_no_both_sel: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(s_reg.program_select_bit && s_reg.erase)) // see R15
        else $error("program and erase selected together");

    a_hv_needs_erase: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) erase_hv_out |-> s_reg.erase && s_reg.high_voltage_enable) // see R16
        else $error("erase voltage without erase and enable");

    a_trim_vec_only: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) trim_erase_out |-> vec_page_out && erase_hv_out) // see R13
        else $error("trim erased outside vector page erase");

    a_read_after_rcv: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) hv_drop_s |-> ##[1:12] read_ok_out) // see R10
        else $error("array not readable after recovery");

    a_page_aligned: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (s_reg.st == FPEC_IDLE && s_next.st == FPEC_ARMED)
        |=> page_out == $past(addr_in[15:6])) // see R1
        else $error("page latch mismatch");

    a_no_read_hv: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) erase_hv_out |-> !read_ok_out) // see R10
        else $error("array readable under high voltage");
endmodule
`default_nettype wire
